// ### rtl/sleep_and_reset_control_pkg.sv
// Constants for the sleep and reset controller.
// Assumes a single 20 MHz system clock.
package sleep_and_reset_control_pkg;

    // ====================================================================
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned RELEASE_NS    = 1000;
    localparam int unsigned RELEASE_CYC   = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_W        = 5;
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RELEASE_CYC);

    // ====================================================================
    // Sleep mode codes
    localparam logic [2:0] MODE_IDLE     = 3'h0;
    localparam logic [2:0] MODE_ADC_NR   = 3'h1;
    localparam logic [2:0] MODE_PDOWN    = 3'h2;
    localparam logic [2:0] MODE_PSAVE    = 3'h3;
    localparam logic [2:0] MODE_STANDBY  = 3'h6;
    localparam logic [2:0] MODE_EXT_STBY = 3'h7;

    // ====================================================================
    // Clock domain enable vector: {cpu, io, osc, async timer, adc}
    localparam int unsigned DOM_CPU   = 4;
    localparam int unsigned DOM_IO    = 3;
    localparam int unsigned DOM_OSC   = 2;
    localparam int unsigned DOM_ASYNC = 1;
    localparam int unsigned DOM_ADC   = 0;
    localparam logic [4:0] DOM_RUN      = 5'h1F;
    localparam logic [4:0] DOM_IDLE     = 5'h0F;
    localparam logic [4:0] DOM_ADC_NR   = 5'h07;
    localparam logic [4:0] DOM_PDOWN    = 5'h00;
    localparam logic [4:0] DOM_PSAVE    = 5'h02;
    localparam logic [4:0] DOM_STANDBY  = 5'h04;
    localparam logic [4:0] DOM_EXT_STBY = 5'h06;
    localparam logic [4:0] DOM_WAKE     = 5'h0F;
    localparam logic [4:0] DOM_RESET    = 5'h04;

    // ====================================================================
    // Ports
    localparam int unsigned PORT_W   = 8;
    localparam int unsigned NUM_PORT = 4;
    localparam int unsigned PIN_W    = PORT_W * NUM_PORT;

    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} state_e;

endpackage

// ### rtl/sleep_and_reset_control.sv
// Sleep mode clock gating, external reset handling and port pin control.
// Assumes inputs synchronous to clk except reset_pin_n, which may arrive
// with the clock stopped.
//
// Summary of operation
// [R1] Idle stops the processor clock; memory, timers, SPI and interrupts keep running.
// [R2] Power-down stops oscillator and everything; only interrupt or reset wakes.
// [R3] Power-save keeps only the asynchronous timer running.
// [R4] Converter noise-reduction stops processor and I/O, keeps async timer and converter.
// [R5] Standby keeps only the main oscillator running for fast wake-up.
// [R6] Extended standby keeps main oscillator and asynchronous timer running.
// [R7] Low reset pin resets the chip even without clock; source must hold it long.
// [R8] All port pins go high-impedance during any reset; only a reset-pin reset floats them without clock.
// [R9] Every bit of the four 8-bit ports has its own pull-up enable.
// [R10] First port is a digital port only while the converter is unused.
// [R11] Legacy fuse removes the watchdog timed-sequence protection.
// [R12] Legacy fuse makes the serial receiver single buffered.
// [R13] Wake-up restores gated domains, then resumes the processor.
`timescale 1ns/1ns
`default_nettype none

module sleep_and_reset_control
    import sleep_and_reset_control_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             reset_pin_n,
    input  wire logic             sleep_req,
    input  wire logic [2:0]       sleep_mode,
    input  wire logic             wake_irq,
    input  wire logic             adc_in_use,
    input  wire logic             legacy_compat_fuse,
    input  wire logic [PIN_W-1:0] port_data,
    input  wire logic [PIN_W-1:0] port_dir,
    input  wire logic [PIN_W-1:0] pullup_sel,
    output logic                  sys_rst_n_o,
    output logic                  cpu_clk_en,
    output logic                  io_clk_en,
    output logic                  osc_en,
    output logic                  async_tmr_clk_en,
    output logic                  adc_clk_en,
    output logic                  wake_pulse,
    output logic                  wdt_timed_seq_en,
    output logic                  rx_double_buf_en,
    output logic                  adc_pins_analog,
    output logic [PIN_W-1:0]      pin_o,
    output logic [PIN_W-1:0]      pin_oe,
    output logic [PIN_W-1:0]      pin_pu
);

    // ====================================================================
    // External reset pin
    logic              pin_meta_reg;
    logic              pin_sync_reg;
    logic [HOLD_W-1:0] hold_reg;
    logic [HOLD_W-1:0] hold_next;
    logic              in_reset;

    // [R7] Pin low clears without clock
    always_ff @(posedge clk or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // [R7] Stretch reset after release
    always_comb begin
        hold_next = hold_reg;
        if (!pin_sync_reg) begin
            hold_next = HOLD_LOAD;
        end else if (hold_reg != '0) begin
            hold_next = hold_reg - HOLD_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_reg <= HOLD_LOAD;
        end else begin
            hold_reg <= hold_next;
        end
    end

    assign in_reset = !rst_n || !pin_sync_reg || (hold_reg != '0);

    // ====================================================================
    // Sleep state machine
    state_e     state_reg;
    state_e     state_next;
    logic [2:0] mode_reg;
    logic [2:0] mode_next;
    logic       mode_ok;

    always_comb begin
        unique case (sleep_mode)
            MODE_IDLE, MODE_ADC_NR, MODE_PDOWN, MODE_PSAVE,
            MODE_STANDBY, MODE_EXT_STBY: mode_ok = 1'b1;
            default:                     mode_ok = 1'b0;
        endcase
    end

    // [R2] [R13] Enter on request, leave on interrupt
    always_comb begin
        state_next = state_reg;
        mode_next  = mode_reg;
        if (in_reset) begin
            state_next = ST_RUN;
            mode_next  = MODE_IDLE;
        end else begin
            unique case (state_reg)
                ST_RUN: begin
                    if (sleep_req && mode_ok) begin
                        state_next = ST_SLEEP;
                        mode_next  = sleep_mode;
                    end
                end
                ST_SLEEP: begin
                    if (wake_irq) begin
                        state_next = ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    state_next = ST_RUN;
                end
                default: state_next = ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
            mode_reg  <= MODE_IDLE;
        end else begin
            state_reg <= state_next;
            mode_reg  <= mode_next;
        end
    end

    // ====================================================================
    // Clock domain enables
    logic [4:0] dom_reg;
    logic [4:0] dom_next;
    logic       wake_next;

    always_comb begin
        dom_next  = DOM_RUN;
        wake_next = 1'b0;
        if (in_reset) begin
            dom_next = DOM_RESET;
        end else begin
            unique case (state_next)
                ST_RUN: dom_next = DOM_RUN;
                ST_WAKE: begin
                    // [R13] Domains back before processor
                    dom_next  = DOM_WAKE;
                    wake_next = 1'b1;
                end
                ST_SLEEP: begin
                    unique case (mode_next)
                        // [R1] Idle gating
                        MODE_IDLE:     dom_next = DOM_IDLE;
                        // [R4] Noise reduction gating
                        MODE_ADC_NR:   dom_next = DOM_ADC_NR;
                        // [R2] Power-down gating
                        MODE_PDOWN:    dom_next = DOM_PDOWN;
                        // [R3] Power-save gating
                        MODE_PSAVE:    dom_next = DOM_PSAVE;
                        // [R5] Standby gating
                        MODE_STANDBY:  dom_next = DOM_STANDBY;
                        // [R6] Extended standby gating
                        MODE_EXT_STBY: dom_next = DOM_EXT_STBY;
                        default:       dom_next = DOM_RUN;
                    endcase
                end
                default: dom_next = DOM_RUN;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dom_reg    <= DOM_RESET;
            wake_pulse <= 1'b0;
        end else begin
            dom_reg    <= dom_next;
            wake_pulse <= wake_next;
        end
    end

    assign cpu_clk_en       = dom_reg[DOM_CPU];
    assign io_clk_en        = dom_reg[DOM_IO];
    assign osc_en           = dom_reg[DOM_OSC];
    assign async_tmr_clk_en = dom_reg[DOM_ASYNC];
    assign adc_clk_en       = dom_reg[DOM_ADC];

    // ====================================================================
    // Reset output and fuse options
    logic rst_out_next;
    logic wdt_next;
    logic rxbuf_next;

    always_comb begin
        rst_out_next = !in_reset;
        // [R11] Fuse drops timed sequence
        wdt_next     = !legacy_compat_fuse;
        // [R12] Fuse selects single buffering
        rxbuf_next   = !legacy_compat_fuse;
    end

    // [R7] Reset output clears without clock
    always_ff @(posedge clk or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            sys_rst_n_o <= 1'b0;
        end else begin
            sys_rst_n_o <= rst_out_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wdt_timed_seq_en <= 1'b1;
            rx_double_buf_en <= 1'b1;
        end else begin
            wdt_timed_seq_en <= wdt_next;
            rx_double_buf_en <= rxbuf_next;
        end
    end

    // ====================================================================
    // Port pins
    logic [PIN_W-1:0] oe_next;
    logic [PIN_W-1:0] pu_next;
    logic [PIN_W-1:0] o_next;
    logic             analog_next;

    // [R10] First port analog while converter used
    assign analog_next = !in_reset && adc_in_use;

    generate
        for (genvar b = 0; b < PIN_W; b++) begin : g_pin
            logic analog_bit;
            assign analog_bit = (b < PORT_W) && adc_in_use;
            // [R9] Per-bit pull-up select
            assign pu_next[b] = !in_reset && !analog_bit && !port_dir[b] && pullup_sel[b];
            // [R8] Released only outside reset
            assign oe_next[b] = !in_reset && !analog_bit && port_dir[b];
            assign o_next[b]  = !in_reset && port_data[b];
        end
    endgenerate

    // [R8] Pins float without clock
    always_ff @(posedge clk or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            pin_oe          <= '0;
            pin_pu          <= '0;
            pin_o           <= '0;
            adc_pins_analog <= 1'b0;
        end else begin
            pin_oe          <= oe_next;
            pin_pu          <= pu_next;
            pin_o           <= o_next;
            adc_pins_analog <= analog_next;
        end
    end

    // ====================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_idle;
        state_reg == ST_SLEEP && mode_reg == MODE_IDLE && !in_reset
            |=> !cpu_clk_en && io_clk_en && osc_en;
    endproperty
    a_idle: assert property (p_idle) else $error("idle gating wrong"); // [R1]
    property p_pdown;
        state_reg == ST_SLEEP && mode_reg == MODE_PDOWN && !wake_irq && !in_reset
            |=> dom_reg == DOM_PDOWN;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down gating wrong"); // [R2]
    property p_psave;
        state_reg == ST_SLEEP && mode_reg == MODE_PSAVE && !wake_irq && !in_reset
            |=> async_tmr_clk_en && !osc_en && !cpu_clk_en;
    endproperty
    a_psave: assert property (p_psave) else $error("power-save gating wrong"); // [R3]
    property p_adcnr;
        state_reg == ST_SLEEP && mode_reg == MODE_ADC_NR && !wake_irq && !in_reset
            |=> adc_clk_en && async_tmr_clk_en && !io_clk_en && !cpu_clk_en;
    endproperty
    a_adcnr: assert property (p_adcnr) else $error("noise-reduction gating wrong"); // [R4]
    property p_stby;
        state_reg == ST_SLEEP && mode_reg == MODE_STANDBY && !wake_irq && !in_reset
            |=> osc_en && !async_tmr_clk_en && !cpu_clk_en;
    endproperty
    a_stby: assert property (p_stby) else $error("standby gating wrong"); // [R5]
    property p_ext;
        state_reg == ST_SLEEP && mode_reg == MODE_EXT_STBY && !wake_irq && !in_reset
            |=> osc_en && async_tmr_clk_en && !io_clk_en;
    endproperty
    a_ext: assert property (p_ext) else $error("extended standby gating wrong"); // [R6]
    property p_rst;
        !pin_sync_reg |=> !sys_rst_n_o [*8];
    endproperty
    a_rst: assert property (p_rst) else $error("reset not held"); // [R7]
    property p_tri;
        !sys_rst_n_o |-> pin_oe == '0 && pin_pu == '0;
    endproperty
    a_tri: assert property (p_tri) else $error("pins driven in reset"); // [R8]
    property p_analog;
        disable iff (!rst_n || !reset_pin_n)
        adc_in_use && !in_reset |=> pin_oe[PORT_W-1:0] == '0 && adc_pins_analog;
    endproperty
    a_analog: assert property (p_analog) else $error("first port driven"); // [R10]
    property p_fuse;
        ##1 $stable(legacy_compat_fuse)
            |-> wdt_timed_seq_en == !$past(legacy_compat_fuse)
                && rx_double_buf_en == !$past(legacy_compat_fuse);
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse options wrong"); // [R11]
    property p_wake;
        state_reg == ST_SLEEP && wake_irq && !in_reset
            |=> wake_pulse && !cpu_clk_en ##1 cpu_clk_en;
    endproperty
    a_wake: assert property (p_wake) else $error("wake sequence wrong"); // [R13]

    c_idle:  cover property (state_reg == ST_SLEEP && mode_reg == MODE_IDLE);
    c_pdown: cover property (state_reg == ST_SLEEP && mode_reg == MODE_PDOWN ##1 wake_pulse);
    c_rst:   cover property ($rose(sys_rst_n_o));
    c_adc:   cover property (adc_in_use && adc_pins_analog);

endmodule

`default_nettype wire

// ### bench/reset_source_model.sv
// Board-side model of the external reset source on the reset pin.
// Assumes a 50 ns system clock; pulse lengths are given in cycles.
`timescale 1ns/1ns
`default_nettype none

module reset_source_model #(
    parameter int MIN_PULSE_CYC = 4
) (
    input  wire logic       go,
    input  wire logic [7:0] len,
    output logic            reset_pin_n
);
    // ====================================================================
    // Pulse generation, independent of any clock
    initial reset_pin_n = 1'b1;

    always @(posedge go) begin
        reset_pin_n = 1'b0;
        #((len > MIN_PULSE_CYC ? len : MIN_PULSE_CYC + 1) * 50);
        reset_pin_n = 1'b1;
    end
endmodule

`default_nettype wire

// ### bench/sleep_and_reset_control_tb_top.sv
// Self-checking bench for the sleep and reset controller.
// Assumes the package constants and the reset source model.
`timescale 1ns/1ns
`default_nettype none

module sleep_and_reset_control_tb_top;
    import sleep_and_reset_control_pkg::*;

    typedef struct {
        bit               dk;
        int               due;
        logic [5:0]       dom;
        logic [PIN_W-1:0] oe;
        logic [PIN_W-1:0] o;
        logic [PIN_W-1:0] pu;
        logic             ana;
        logic             fz;
        logic             sr;
    } note_s;

    logic             clk, rst_n, sleep_req, wake_irq, adc_in_use, legacy_compat_fuse;
    logic             go, clk_run;
    logic [2:0]       sleep_mode;
    logic [7:0]       len;
    logic [PIN_W-1:0] port_data, port_dir, pullup_sel, pin_o, pin_oe, pin_pu;
    wire logic        reset_pin_n;
    logic             sys_rst_n_o, cpu_clk_en, io_clk_en, osc_en, async_tmr_clk_en;
    logic             adc_clk_en, wake_pulse, wdt_timed_seq_en, rx_double_buf_en;
    logic             adc_pins_analog;
    int               cyc, err_total, n_compared;
    logic [31:0]      seed, tmp;
    note_s            q[$];
    note_s            cur;
    event             chk_ev;
    logic [2:0]       modes[6] = '{MODE_IDLE, MODE_ADC_NR, MODE_PDOWN, MODE_PSAVE,
                                   MODE_STANDBY, MODE_EXT_STBY};
    logic [4:0]       doms[6]  = '{DOM_IDLE, DOM_ADC_NR, DOM_PDOWN, DOM_PSAVE,
                                   DOM_STANDBY, DOM_EXT_STBY};

    // ====================================================================
    // Clock, design and partner
    initial clk = 1'b0;
    always #25 if (clk_run) clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    sleep_and_reset_control dut_u (
        .clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .sleep_req(sleep_req),
        .sleep_mode(sleep_mode), .wake_irq(wake_irq), .adc_in_use(adc_in_use),
        .legacy_compat_fuse(legacy_compat_fuse), .port_data(port_data),
        .port_dir(port_dir), .pullup_sel(pullup_sel), .sys_rst_n_o(sys_rst_n_o),
        .cpu_clk_en(cpu_clk_en), .io_clk_en(io_clk_en), .osc_en(osc_en),
        .async_tmr_clk_en(async_tmr_clk_en), .adc_clk_en(adc_clk_en),
        .wake_pulse(wake_pulse), .wdt_timed_seq_en(wdt_timed_seq_en),
        .rx_double_buf_en(rx_double_buf_en), .adc_pins_analog(adc_pins_analog),
        .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu)
    );

    reset_source_model rst_src_u (.go(go), .len(len), .reset_pin_n(reset_pin_n));

    // ====================================================================
    // Notes and comparisons
    task automatic fail(string m);
        err_total++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic dnote(int d, logic [5:0] e);
        note_s n;
        n = '{default: '0};
        n.dk = 1'b1;
        n.due = d;
        n.dom = e;
        q.push_back(n);
    endtask

    function automatic note_s io_note(int d, logic sr);
        note_s            n;
        logic [PIN_W-1:0] m;
        m = adc_in_use ? 32'hFFFFFF00 : 32'hFFFFFFFF;
        n.dk = 1'b0;
        n.due = d;
        n.dom = '0;
        n.oe = sr ? port_dir & m : '0;
        n.o = sr ? port_data : '0;
        n.pu = sr ? ~port_dir & pullup_sel & m : '0;
        n.ana = sr & adc_in_use;
        n.fz = legacy_compat_fuse;
        n.sr = sr;
        return n;
    endfunction

    task automatic cmp_dom(note_s n);
        n_compared++;
        if ({cpu_clk_en, io_clk_en, osc_en, async_tmr_clk_en, adc_clk_en, wake_pulse}
            !== n.dom) fail("domain enables or wake pulse wrong");
    endtask

    task automatic cmp_io(note_s n);
        n_compared++;
        if (pin_oe !== n.oe || (pin_o & n.oe) !== (n.o & n.oe) || pin_pu !== n.pu ||
            adc_pins_analog !== n.ana || sys_rst_n_o !== n.sr ||
            wdt_timed_seq_en !== ~n.fz || rx_double_buf_en !== ~n.fz)
            fail("pins, reset or fuse outputs wrong");
    endtask

    always @(negedge clk or chk_ev) begin
        while (q.size() > 0 && q[0].due <= cyc) begin
            cur = q.pop_front();
            if (cur.dk) cmp_dom(cur);
            else cmp_io(cur);
        end
    end

    // ====================================================================
    // Stimulus
    task automatic sleep_in(logic [2:0] m, logic [5:0] e);
        sleep_mode = m;
        sleep_req = 1'b1;
        dnote(cyc + 1, e);
        @(negedge clk);
        sleep_req = 1'b0;
        dnote(cyc + 3, e);
        repeat (3) @(negedge clk);
    endtask

    task automatic wake(logic [5:0] e1, logic [5:0] e2);
        wake_irq = 1'b1;
        dnote(cyc + 1, e1);
        dnote(cyc + 2, e2);
        @(negedge clk);
        wake_irq = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic conclude();
        if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #(2000 * 50);
        err_total++;
        conclude();
    end

    initial begin
        {rst_n, sleep_req, wake_irq, adc_in_use, legacy_compat_fuse, go} = '0;
        {sleep_mode, port_data, port_dir, pullup_sel} = '0;
        {cyc, err_total, n_compared} = '0;
        clk_run = 1'b1;
        len = 8'h1E;
        seed = 32'h47d5f013;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        q.push_back(io_note(cyc + 30, 1'b1));
        repeat (31) @(negedge clk);
        for (int i = 0; i < 6; i++) begin
            sleep_in(modes[i], {doms[i], 1'b0});
            sleep_in(MODE_IDLE, {doms[i], 1'b0});
            wake({DOM_WAKE, 1'b1}, {DOM_RUN, 1'b0});
        end
        sleep_in(3'h4, {DOM_RUN, 1'b0});
        sleep_in(3'h5, {DOM_RUN, 1'b0});
        wake({DOM_RUN, 1'b0}, {DOM_RUN, 1'b0});
        repeat (40) begin
            @(negedge clk);
            port_data = $random(seed);
            port_dir = $random(seed);
            pullup_sel = $random(seed);
            tmp = $random(seed);
            adc_in_use = tmp[0];
            legacy_compat_fuse = tmp[1];
            q.push_back(io_note(cyc + 1, 1'b1));
        end
        @(negedge clk);
        legacy_compat_fuse = 1'b0;
        @(negedge clk);
        clk_run = 1'b0;
        #100 go = 1'b1;
        #10 q.push_back(io_note(cyc, 1'b0));
        ->chk_ev;
        #1000 clk_run = 1'b1;
        go = 1'b0;
        wait (reset_pin_n === 1'b1);
        @(negedge clk);
        q.push_back(io_note(cyc + 10, 1'b0));
        q.push_back(io_note(cyc + 30, 1'b1));
        repeat (32) @(negedge clk);
        rst_n = 1'b0;
        dnote(cyc + 1, {DOM_RESET, 1'b0});
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        q.push_back(io_note(cyc + 30, 1'b1));
        repeat (32) @(negedge clk);
        conclude();
    end
endmodule

`default_nettype wire
